// File: dspc_map.vh
// register map, bit positions, modes and timing counts of the debug
// serial port control block; definitions only, included by bare name
`ifndef DSPC_MAP_VH
`define DSPC_MAP_VH

`define DSPC_CTRL_ADDR   8'h98
`define DSPC_DATA_ADDR   8'h99
`define DSPC_CTRL_RST    8'h00
`define DSPC_NULL_RD     8'h00

`define DSPC_B_MODE_HI   7
`define DSPC_B_MODE_LO   6
`define DSPC_B_MP_EN     5
`define DSPC_B_RX_EN     4
`define DSPC_B_TX_B9     3
`define DSPC_B_RX_B9     2
`define DSPC_B_TX_DONE   1
`define DSPC_B_RX_DONE   0

`define DSPC_MODE_SHIFT  2'h0
`define DSPC_MODE_ASYNC8 2'h1
`define DSPC_MODE_FIXED9 2'h2
`define DSPC_MODE_VAR9   2'h3

`define DSPC_CLK_MHZ     100
`define DSPC_M0_DIV      6
`define DSPC_M0_BITS     8
`define DSPC_M0_END      (`DSPC_M0_DIV * `DSPC_M0_BITS)
`define DSPC_M0_PH_LAST  3'h5
`define DSPC_M0_PH_HALF  3'h3

`define DSPC_OVS_LAST    4'hf
`define DSPC_OVS_MID     4'h7
`define DSPC_DIV64_TICK  2'h3
`define DSPC_DIV32_TICK  2'h1
`define DSPC_TI_IDX8     4'h7
`define DSPC_TI_IDX9     4'h8
`define DSPC_END_IDX8    4'h9
`define DSPC_END_IDX9    4'ha
`define DSPC_RX_LAST     4'h9

`endif

// File: dspc_rate_gen.v
// sixteen-times oversampling ticks for the asynchronous modes
// assumes timer overflow pulses are one cycle wide and synchronous
`include "dspc_map.vh"
module dspc_rate_gen
(
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       clkEn,
    input  wire [1:0] mode,
    input  wire       smodBit,
    input  wire       rxUseT2,
    input  wire       txUseT2,
    input  wire       t1Ovf,
    input  wire       t2Ovf,
    output wire       rxTick,
    output wire       txTick
);
    reg  [1:0] divCnt_ff;
    reg        t1Half_ff;
    wire [1:0] divLast;
    wire       divTick;
    wire       t1Tick;
    wire       fixedMode;

    // fixed rate: 16 ticks of 4 or 2 clocks give 1/64 or 1/32
    assign divLast   = smodBit ? `DSPC_DIV32_TICK : `DSPC_DIV64_TICK;
    assign divTick   = (divCnt_ff == divLast);
    assign fixedMode = (mode == `DSPC_MODE_FIXED9);
    assign t1Tick    = t1Ovf & (smodBit | t1Half_ff);
    assign rxTick    = fixedMode ? divTick : (rxUseT2 ? t2Ovf : t1Tick);
    assign txTick    = fixedMode ? divTick : (txUseT2 ? t2Ovf : t1Tick);

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            divCnt_ff <= 2'h0;
            t1Half_ff <= 1'b0;
        end
        else if (clkEn)
        begin
            divCnt_ff <= divTick ? 2'h0 : divCnt_ff + 2'h1;
            if (t1Ovf)
                t1Half_ff <= ~t1Half_ff;
        end
    end
endmodule

// File: dspc_rx_buf.v
// small receive buffer with valid and ready on both sides
// assumes the reader pops with outReady only while outValid is high
module dspc_rx_buf
#(
    parameter WIDTH = 8,
    parameter DEPTH = 2,
    parameter AW    = 1
)
(
    input  wire             sys_clk,
    input  wire             rst,
    input  wire             clkEn,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_ff;
    reg [AW-1:0]    rdPtr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;

    assign inReady  = (count_ff != DEPTH[AW:0]);
    assign outValid = (count_ff != {(AW+1){1'b0}});
    assign outData  = mem_ff[rdPtr_ff];
    assign push     = inValid & inReady;
    assign pop      = outReady & outValid;

    function [AW-1:0] bump;
        input [AW-1:0] ptr;
        begin
            bump = (ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : ptr + 1'b1;
        end
    endfunction

    always @(posedge sys_clk)
    begin
        if (clkEn & push)
            mem_ff[wrPtr_ff] <= inData;
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_ff <= {AW{1'b0}};
            rdPtr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end
        else if (clkEn)
        begin
            if (push)
                wrPtr_ff <= bump(wrPtr_ff);
            if (pop)
                rdPtr_ff <= bump(rdPtr_ff);
            if (push & ~pop)
                count_ff <= count_ff + 1'b1;
            else if (pop & ~push)
                count_ff <= count_ff - 1'b1;
        end
    end
endmodule

// File: dspc_serial_ctrl.v
// debug serial port: control/status register, mode 0 shift engine,
// asynchronous transmit and receive engines and receive buffer
// assumes a synchronous special-function bus and synchronous pins
//
// Overview of operation
// - control bits 7..6 pick shift, 8-bit, 9-bit fixed or 9-bit variable
// - shift mode runs at clock/6; fixed 9-bit mode at clock/64 or /32
// - 9-bit modes with filter on drop frames whose ninth bit is 0
// - 8-bit mode with filter on drops frames lacking a valid stop bit
// - filter off means no dropping; shift mode ignores the filter bit
// - reception only while receive enable bit 4 is set by firmware
// - 9-bit modes send transmit ninth bit 3; other modes ignore it
// - received ninth bit or stop bit goes to bit 2; shift mode leaves it
// - transmit flag set after ninth bit time, or eighth in other modes
// - hardware never clears the transmit flag; firmware clears it
// - hardware never clears the receive flag; firmware clears it
// - 9-bit modes raise receive flag one clock after ninth bit sample
// - 8-bit mode raises receive flag one clock after stop bit sample
// - shift mode receive flag at state 1 of ninth machine cycle
// - flags request an interrupt only when the enable input is set
// - read-modify-write never overwrites flag bits hardware just changed
// - 8-bit frame: start 0, eight data bits lsb first, stop 1
// - 9-bit frame: start 0, eight data bits, ninth bit, stop 1
// - shift receive starts on flag 0 and enable; async on start bit
// - a write of the data buffer starts a transmission only while the engine is idle
`include "dspc_map.vh"
module dspc_serial_ctrl
#(
    parameter BUF_DEPTH = 2,
    parameter BUF_AW    = 1
)
(
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       clkEn,
    input  wire [7:0] sfrAddr,
    input  wire       sfrWrEn,
    input  wire       sfrRmw,
    input  wire [7:0] sfrWrData,
    input  wire       sfrRdEn,
    output reg  [7:0] sfrRdData,
    input  wire       serialIrqEnable,
    output reg        serialIrq,
    input  wire       smodBit,
    input  wire       rxUseT2,
    input  wire       txUseT2,
    input  wire       t1Ovf,
    input  wire       t2Ovf,
    input  wire       rxdIn,
    output reg        rxdOut,
    output reg        rxdOe,
    output reg        txdOut
);
    reg  [7:0]  ctrl_ff;
    reg  [7:0]  nxt_ctrl;
    reg  [2:0]  hwMark_ff;
    reg  [2:0]  nxt_hwMark;

    reg         m0Act_ff;
    reg         m0Tx_ff;
    reg  [5:0]  m0Cnt_ff;
    reg  [2:0]  m0Ph_ff;
    reg  [7:0]  m0Sh_ff;

    reg         atAct_ff;
    reg  [3:0]  atTick_ff;
    reg  [3:0]  atBit_ff;
    reg  [10:0] atSh_ff;

    reg         arAct_ff;
    reg  [3:0]  arTick_ff;
    reg  [3:0]  arBit_ff;
    reg  [8:0]  arSh_ff;
    reg         arDone_ff;
    reg         rxPrev_ff;

    wire [1:0]  mode;
    wire        nineBit;
    wire        isShift;
    wire        mpEn;
    wire        rxEn;
    wire        wrCtrl;
    wire        wrData;
    wire        rdCtrl;
    wire        rdData;
    wire        rxTick;
    wire        txTick;
    wire        m0TxEnd;
    wire        m0RxEnd;
    wire        m0Go;
    wire        atEdge;
    wire        arSample;
    wire        arAccept;
    wire        pushValid;
    wire [7:0]  pushData;
    wire        bufInReady;
    wire        bufOutValid;
    wire [7:0]  bufOutData;
    wire        setTi;
    wire        setRi;
    wire        setRb8;
    wire        rb8Val;
    wire [7:0]  lockMask;

    assign mode    = {ctrl_ff[`DSPC_B_MODE_HI], ctrl_ff[`DSPC_B_MODE_LO]};
    assign isShift = (mode == `DSPC_MODE_SHIFT);
    assign nineBit = mode[1];
    assign mpEn    = ctrl_ff[`DSPC_B_MP_EN];
    assign rxEn    = ctrl_ff[`DSPC_B_RX_EN];

    assign wrCtrl  = sfrWrEn & (sfrAddr == `DSPC_CTRL_ADDR);
    assign wrData  = sfrWrEn & (sfrAddr == `DSPC_DATA_ADDR);
    assign rdCtrl  = sfrRdEn & (sfrAddr == `DSPC_CTRL_ADDR);
    assign rdData  = sfrRdEn & (sfrAddr == `DSPC_DATA_ADDR);

    function [3:0] tiIdx;
        input nine;
        begin
            tiIdx = nine ? `DSPC_TI_IDX9 : `DSPC_TI_IDX8;
        end
    endfunction

    function [3:0] endIdx;
        input nine;
        begin
            endIdx = nine ? `DSPC_END_IDX9 : `DSPC_END_IDX8;
        end
    endfunction

    dspc_rate_gen u_rate
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .mode    (mode),
        .smodBit (smodBit),
        .rxUseT2 (rxUseT2),
        .txUseT2 (txUseT2),
        .t1Ovf   (t1Ovf),
        .t2Ovf   (t2Ovf),
        .rxTick  (rxTick),
        .txTick  (txTick)
    );

    dspc_rx_buf
    #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH),
        .AW    (BUF_AW)
    )
    u_buf
    (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .inValid  (pushValid),
        .inReady  (bufInReady),
        .inData   (pushData),
        .outValid (bufOutValid),
        .outReady (rdData),
        .outData  (bufOutData)
    );

    // mode 0: one bit per six clocks, clock out on txd, data on rxd
    assign m0TxEnd = m0Act_ff & m0Tx_ff & (m0Cnt_ff == `DSPC_M0_END - 1);
    assign m0RxEnd = m0Act_ff & ~m0Tx_ff & (m0Cnt_ff == `DSPC_M0_END);
    assign m0Go    = isShift & rxEn & ~ctrl_ff[`DSPC_B_RX_DONE]
                     & ~m0Act_ff & ~wrData;

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            m0Act_ff <= 1'b0;
            m0Tx_ff  <= 1'b0;
            m0Cnt_ff <= 6'h00;
            m0Ph_ff  <= 3'h0;
            m0Sh_ff  <= 8'h00;
        end
        else if (clkEn)
        begin
            if (!m0Act_ff)
            begin
                m0Cnt_ff <= 6'h00;
                m0Ph_ff  <= 3'h0;
                if (isShift & wrData)
                begin
                    m0Act_ff <= 1'b1;
                    m0Tx_ff  <= 1'b1;
                    m0Sh_ff  <= sfrWrData;
                end
                else if (m0Go)
                begin
                    m0Act_ff <= 1'b1;
                    m0Tx_ff  <= 1'b0;
                end
            end
            else
            begin
                m0Cnt_ff <= m0Cnt_ff + 6'h01;
                m0Ph_ff  <= (m0Ph_ff == `DSPC_M0_PH_LAST) ? 3'h0
                                                           : m0Ph_ff + 3'h1;
                if ((m0Ph_ff == `DSPC_M0_PH_LAST)
                    && (m0Cnt_ff < `DSPC_M0_END))
                    m0Sh_ff <= m0Tx_ff ? {1'b0, m0Sh_ff[7:1]}
                                       : {rxdIn, m0Sh_ff[7:1]};
                if (m0TxEnd | m0RxEnd)
                    m0Act_ff <= 1'b0;
            end
        end
    end

    // asynchronous transmit, sixteen ticks per bit
    assign atEdge = atAct_ff & txTick & (atTick_ff == `DSPC_OVS_LAST);

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            atAct_ff  <= 1'b0;
            atTick_ff <= 4'h0;
            atBit_ff  <= 4'h0;
            atSh_ff   <= 11'h7ff;
        end
        else if (clkEn)
        begin
            if (!atAct_ff)
            begin
                if (!isShift & wrData)
                begin
                    atAct_ff  <= 1'b1;
                    atTick_ff <= 4'h0;
                    atBit_ff  <= 4'h0;
                    if (nineBit)
                        atSh_ff <= {1'b1, ctrl_ff[`DSPC_B_TX_B9],
                                    sfrWrData, 1'b0};
                    else
                        atSh_ff <= {2'b11, sfrWrData, 1'b0};
                end
            end
            else if (txTick)
            begin
                atTick_ff <= atTick_ff + 4'h1;
                if (atEdge)
                begin
                    atSh_ff  <= {1'b1, atSh_ff[10:1]};
                    atBit_ff <= atBit_ff + 4'h1;
                    if (atBit_ff == endIdx(nineBit))
                        atAct_ff <= 1'b0;
                end
            end
        end
    end

    // asynchronous receive, sampled at mid bit
    assign arSample = arAct_ff & rxTick & (arTick_ff == `DSPC_OVS_MID);

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            arAct_ff  <= 1'b0;
            arTick_ff <= 4'h0;
            arBit_ff  <= 4'h0;
            arSh_ff   <= 9'h000;
            arDone_ff <= 1'b0;
            rxPrev_ff <= 1'b1;
        end
        else if (clkEn)
        begin
            rxPrev_ff <= rxdIn;
            arDone_ff <= 1'b0;
            if (!arAct_ff)
            begin
                if (!isShift & rxEn & rxPrev_ff & ~rxdIn)
                begin
                    arAct_ff  <= 1'b1;
                    arTick_ff <= 4'h0;
                    arBit_ff  <= 4'h0;
                end
            end
            else if (rxTick)
            begin
                arTick_ff <= arTick_ff + 4'h1;
                if (arSample)
                begin
                    arBit_ff <= arBit_ff + 4'h1;
                    if (arBit_ff == 4'h0)
                    begin
                        if (rxdIn)
                            arAct_ff <= 1'b0;
                    end
                    else
                        arSh_ff <= {rxdIn, arSh_ff[8:1]};
                    // ninth bit or stop bit ends the frame here
                    if (arBit_ff == `DSPC_RX_LAST)
                    begin
                        arAct_ff  <= 1'b0;
                        arDone_ff <= 1'b1;
                    end
                end
            end
        end
    end

    // filter: bit 8 holds the ninth bit or the mode 1 stop bit
    assign arAccept  = arDone_ff & (~mpEn | arSh_ff[8]);
    assign pushValid = arAccept | m0RxEnd;
    assign pushData  = m0RxEnd ? m0Sh_ff : arSh_ff[7:0];

    // a full buffer drops the frame without touching flags
    assign setRi  = pushValid & bufInReady;
    assign setRb8 = arAccept & bufInReady;
    assign rb8Val = arSh_ff[8];
    assign setTi  = m0TxEnd | (atEdge & (atBit_ff == tiIdx(nineBit)));

    assign lockMask = sfrRmw ? {5'h00, hwMark_ff} : 8'h00;

    always @*
    begin
        nxt_ctrl   = ctrl_ff;
        nxt_hwMark = rdCtrl ? 3'h0 : hwMark_ff;
        if (wrCtrl)
            nxt_ctrl = (sfrWrData & ~lockMask) | (ctrl_ff & lockMask);
        if (setRb8)
            nxt_ctrl[`DSPC_B_RX_B9] = rb8Val;
        if (setTi)
            nxt_ctrl[`DSPC_B_TX_DONE] = 1'b1;
        if (setRi)
            nxt_ctrl[`DSPC_B_RX_DONE] = 1'b1;
        nxt_hwMark = nxt_hwMark | {setRb8, setTi, setRi};
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff   <= `DSPC_CTRL_RST;
            hwMark_ff <= 3'h0;
            sfrRdData <= `DSPC_NULL_RD;
            serialIrq <= 1'b0;
            rxdOut    <= 1'b1;
            rxdOe     <= 1'b0;
            txdOut    <= 1'b1;
        end
        else if (clkEn)
        begin
            ctrl_ff   <= nxt_ctrl;
            hwMark_ff <= nxt_hwMark;
            if (rdCtrl)
                sfrRdData <= ctrl_ff;
            else if (rdData)
                sfrRdData <= bufOutValid ? bufOutData : `DSPC_NULL_RD;
            else if (sfrRdEn)
                sfrRdData <= `DSPC_NULL_RD;
            serialIrq <= serialIrqEnable
                         & (ctrl_ff[`DSPC_B_TX_DONE]
                            | ctrl_ff[`DSPC_B_RX_DONE]);
            rxdOut <= (m0Act_ff & m0Tx_ff) ? m0Sh_ff[0] : 1'b1;
            rxdOe  <= m0Act_ff & m0Tx_ff & (m0Cnt_ff < `DSPC_M0_END);
            if (m0Act_ff & (m0Cnt_ff < `DSPC_M0_END))
                txdOut <= (m0Ph_ff >= `DSPC_M0_PH_HALF);
            else if (atAct_ff)
                txdOut <= atSh_ff[0];
            else
                txdOut <= 1'b1;
        end
    end
endmodule

// File: dspc_serial_ctrl_asserts.sv
// checker: bus, interrupt request and shift-mode pin timing
// bound to the top module, sees its ports only
module dspc_serial_ctrl_asserts
(
    input wire       sys_clk,
    input wire       rst,
    input wire [7:0] sfrAddr,
    input wire       sfrWrEn,
    input wire       sfrRmw,
    input wire [7:0] sfrWrData,
    input wire       sfrRdEn,
    input wire [7:0] sfrRdData,
    input wire       serialIrqEnable,
    input wire       serialIrq,
    input wire       rxdOe,
    input wire       txdOut
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wire       wrCtl = sfrWrEn && sfrAddr == 8'h98;
    wire       wrDat = sfrWrEn && sfrAddr == 8'h99;
    wire       rdCtl = sfrRdEn && sfrAddr == 8'h98;
    reg  [5:0] oeRun_ff;
    wire [5:0] nxt_oeRun = rxdOe ? oeRun_ff + 6'h01 : 6'h00;
    // length of the current data-pin drive run
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            oeRun_ff <= 6'h00;
        else
            oeRun_ff <= nxt_oeRun;
    end
    property p_irqGate;
        !serialIrqEnable |=> !serialIrq;
    endproperty
    a_irqGate: assert property (p_irqGate)
        else $error("irq while disabled");
    property p_irqRise;
        $rose(serialIrq) |-> $past(serialIrqEnable);
    endproperty
    a_irqRise: assert property (p_irqRise)
        else $error("irq rose without enable");
    property p_flagHold;
        serialIrq && serialIrqEnable && !$past(wrCtl) |=> serialIrq;
    endproperty
    a_flagHold: assert property (p_flagHold)
        else $error("flag dropped by hardware");
    property p_irqFall;
        $fell(serialIrq) |-> $past(wrCtl, 2) || !$past(serialIrqEnable);
    endproperty
    a_irqFall: assert property (p_irqFall)
        else $error("irq fell without cause");
    property p_oeLen;
        $fell(rxdOe) |-> oeRun_ff == 6'h30;
    endproperty
    a_oeLen: assert property (p_oeLen)
        else $error("shift frame length wrong");
    property p_shiftClk;
        rxdOe && $fell(txdOut) |-> !txdOut [*3] ##1 txdOut;
    endproperty
    a_shiftClk: assert property (p_shiftClk)
        else $error("shift clock low phase wrong");
    property p_fwBits;
        wrCtl && !sfrRmw ##1 !sfrWrEn ##1 rdCtl |=>
            (sfrRdData & 8'hf8) == ($past(sfrWrData, 3) & 8'hf8);
    endproperty
    a_fwBits: assert property (p_fwBits)
        else $error("firmware bits not kept");
    property p_txStart;
        $rose(rxdOe) |-> $past(wrDat) || $past(wrDat, 2);
    endproperty
    a_txStart: assert property (p_txStart)
        else $error("shift transmit without data write");
endmodule

bind dspc_serial_ctrl dspc_serial_ctrl_asserts dspc_serial_ctrl_asserts_i
(
    .sys_clk(sys_clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrRmw(sfrRmw), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
    .sfrRdData(sfrRdData), .serialIrqEnable(serialIrqEnable),
    .serialIrq(serialIrq), .rxdOe(rxdOe), .txdOut(txdOut)
);

// File: dspc_term_model.sv
// serial terminal: drives frames into the receive pin, decodes frames
// from the transmit line; bit time is BIT clocks, line idles high
module dspc_term_model
#(
    parameter BIT = 32
)
(
    input  wire  sysClk,
    input  wire  txLine,
    output logic rxLine
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
        rxLine = 1'b1;
    task automatic send(input logic [7:0] d, input logic b9,
                        input logic nine, input logic stp);
        logic [10:0] f;
        f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
        @(negedge sysClk);
        rxLine = 1'b1;
        repeat (BIT) @(negedge sysClk);
        for (int i = 0; i < 11; i++)
        begin
            rxLine = f[i];
            repeat (BIT) @(negedge sysClk);
        end
    endtask
    task automatic shiftIn(input logic [7:0] d);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge txLine);
            @(negedge sysClk);
            rxLine = d[i];
        end
        @(posedge txLine);
        repeat (4) @(negedge sysClk);
        rxLine = ~d[7];
    endtask
    task automatic recv(input logic nine, output logic [9:0] v);
        v = '0;
        @(negedge txLine);
        repeat (BIT / 2) @(posedge sysClk);
        for (int i = 0; i < (nine ? 10 : 9); i++)
        begin
            repeat (BIT) @(posedge sysClk);
            v[i] = txLine;
        end
        repeat (BIT) @(posedge sysClk);
    endtask
endmodule

// File: dspc_serial_ctrl_tb_top.sv
// testbench: bus tasks, queue model of received bytes, frame checks
// assumes the terminal model and the bound checker are compiled too
module dspc_serial_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sysClk, rst, sfrWrEn, sfrRmw, sfrRdEn, serialIrqEnable;
    logic       smodBit, t1Ovf, termLine, nb, mp, en, ok;
    logic [1:0] mb;
    logic [7:0] sfrAddr, sfrWrData, d, v;
    logic [9:0] fr;
    logic [7:0] rxq[$];
    wire  [7:0] sfrRdData;
    wire        serialIrq, rxdOut, rxdOe, txdOut;
    wire        pinLevel = rxdOe ? rxdOut : termLine;
    int         errors, num_checks, cyc;
    dspc_serial_ctrl dspc_serial_ctrl_i
    (
        .sys_clk(sysClk), .rst(rst), .clkEn(1'b1), .sfrAddr(sfrAddr),
        .sfrWrEn(sfrWrEn), .sfrRmw(sfrRmw), .sfrWrData(sfrWrData),
        .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
        .serialIrqEnable(serialIrqEnable), .serialIrq(serialIrq),
        .smodBit(smodBit), .rxUseT2(1'b0), .txUseT2(1'b0),
        .t1Ovf(t1Ovf), .t2Ovf(1'b0), .rxdIn(pinLevel),
        .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut)
    );
    dspc_term_model dspc_term_model_i
    (
        .sysClk(sysClk), .txLine(txdOut), .rxLine(termLine)
    );
    initial
    begin
        sysClk = 1'b0;
        forever #5 sysClk = ~sysClk;
    end
    always @(negedge sysClk)
        t1Ovf <= ~t1Ovf;
    always @(posedge sysClk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            final_report();
        end
    end
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic chk10(input string s, input logic [9:0] e,
                         input logic [9:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x, input logic m);
        @(negedge sysClk);
        sfrAddr = a;
        sfrWrData = x;
        sfrRmw = m;
        sfrWrEn = 1'b1;
        @(negedge sysClk);
        sfrWrEn = 1'b0;
        sfrRmw = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(negedge sysClk);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge sysClk);
        sfrRdEn = 1'b0;
        @(negedge sysClk);
        x = sfrRdData;
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        {sfrWrEn, sfrRmw, sfrRdEn, serialIrqEnable, t1Ovf} = '0;
        {sfrAddr, sfrWrData} = '0;
        smodBit = 1'b1;
        void'($urandom(32'hff39));
        repeat (6) @(posedge sysClk);
        @(negedge sysClk);
        rst = 1'b0;
        rd(8'h98, v);
        chk("ctrl reset", 8'h00, v);
        d = ($urandom & 8'he8) | 8'h08;
        wr(8'h98, d, 1'b0);
        rd(8'h98, v);
        chk("ctrl fw bits", d, v);
        rd(8'h5a, v);
        chk("unmapped", 8'h00, v);
        // shift mode transmit, lock, interrupt
        wr(8'h98, 8'h00, 1'b0);
        d = $urandom;
        wr(8'h99, d, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge txdOut);
            v[i] = rxdOut;
        end
        chk("shift tx data", d, v);
        repeat (12) @(negedge sysClk);
        wr(8'h98, 8'h00, 1'b1);
        rd(8'h98, v);
        chk("ctrl locked", 8'h02, v);
        serialIrqEnable = 1'b1;
        repeat (3) @(negedge sysClk);
        chk("irq on", 8'h01, {7'h00, serialIrq});
        serialIrqEnable = 1'b0;
        repeat (3) @(negedge sysClk);
        chk("irq off", 8'h00, {7'h00, serialIrq});
        wr(8'h98, 8'h00, 1'b0);
        rd(8'h98, v);
        chk("tx flag clear", 8'h00, v);
        // shift mode receive with the ninth-bit flag preset
        d = $urandom;
        fork
            wr(8'h98, 8'h14, 1'b0);
            dspc_term_model_i.shiftIn(d);
        join
        repeat (12) @(negedge sysClk);
        rd(8'h98, v);
        chk("shift rx ctrl", 8'h15, v);
        rd(8'h99, v);
        chk("shift rx data", d, v);
        wr(8'h98, 8'h00, 1'b0);
        // async receive: filter, enable and ninth or stop bit
        for (int k = 0; k < 10; k++)
        begin
            nb = k < 8 ? k[1] : k[0];
            mp = k < 8 ? k[0] : 1'b1;
            en = k < 8 ? k[2] : 1'b1;
            mb = k < 8 ? 2'b10 : 2'b01;
            ok = en && (!mp || nb);
            wr(8'h98, {mb, mp, en, 4'h0}, 1'b0);
            d = $urandom;
            dspc_term_model_i.send(d, nb, k < 8, k < 8 || nb);
            if (ok)
                rxq.push_back(d);
            rd(8'h98, v);
            chk("rx ctrl", {mb, mp, en, 1'b0, nb & ok, 1'b0, ok}, v);
            if (ok)
            begin
                rd(8'h99, v);
                chk("rx data", rxq.pop_front(), v);
            end
        end
        // two buffered frames kept, third dropped while reader stalls
        wr(8'h98, 8'h90, 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            d = $urandom;
            dspc_term_model_i.send(d, 1'b1, 1'b1, 1'b1);
            if (k < 2)
                rxq.push_back(d);
        end
        rxq.push_back(8'h00);
        rd(8'h98, v);
        chk("flag kept", 8'h95, v);
        for (int k = 0; k < 3; k++)
        begin
            rd(8'h99, v);
            chk("buffered data", rxq.pop_front(), v);
        end
        // async transmit frames
        for (int k = 0; k < 3; k++)
        begin
            mb = k == 0 ? 2'b10 : (k == 1 ? 2'b11 : 2'b01);
            nb = k[0] | k[1];
            wr(8'h98, {mb, 2'b00, nb, 3'h0}, 1'b0);
            d = $urandom;
            fork
                wr(8'h99, d, 1'b0);
                dspc_term_model_i.recv(k < 2, fr);
            join
            chk10("tx frame", k < 2 ? {1'b1, nb, d} : {2'b01, d}, fr);
            rd(8'h98, v);
            chk("tx flag", {mb, 2'b00, nb, 3'h2}, v);
        end
        final_report();
    end
endmodule
